// >>> core/phy_ctrl_pkg.sv
/*
 * Constants and types shared by the basic control register block:
 * register address, bit positions, reset values, management frame
 * layout and timing counts.
 * Assumes a 250 MHz system clock.
 */
`default_nettype none

package phy_ctrl_pkg;

   // Register location and field positions
   localparam logic [4:0]  CTRL_REG_ADDR    = 5'h00;
   localparam int          BIT_SOFT_RESET   = 15;
   localparam int          BIT_LOOPBACK     = 14;
   localparam int          BIT_RATE         = 13;
   localparam int          BIT_NEG_EN       = 12;
   localparam int          BIT_LOW_POWER    = 11;
   localparam int          BIT_ISOLATE      = 10;
   localparam int          BIT_NEG_RESTART  = 9;
   localparam int          BIT_DUPLEX       = 8;
   localparam int          BIT_COL_TEST     = 7;

   // Writable bits 15..7; bits 6..0 read as zero
   localparam logic [15:0] CTRL_WRITE_MASK  = 16'hFF80;
   // Reset value with isolate clear; isolate comes from the address strap
   localparam logic [15:0] CTRL_RESET_VALUE = 16'h3000;

   // Management frame layout
   localparam logic [5:0]  PREAMBLE_BITS    = 6'h20;
   localparam logic [5:0]  OP_LAST          = 6'h01;
   localparam logic [5:0]  ADDR_LAST        = 6'h09;
   localparam logic [5:0]  TA_LAST          = 6'h01;
   localparam logic [5:0]  DATA_LAST        = 6'h0F;
   localparam logic [1:0]  OP_READ          = 2'h2;
   localparam logic [1:0]  OP_WRITE         = 2'h1;

   // Timing
   localparam int          CLK_PERIOD_PS    = 4000;
   localparam int          SOFT_RESET_NS    = 1000;
   localparam logic [8:0]  SOFT_RESET_COUNT =
      9'((SOFT_RESET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
   localparam logic [2:0]  STRAP_SETTLE     = 3'h5;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_START = 3'h1,
      ST_OP    = 3'h3,
      ST_ADDR  = 3'h2,
      ST_TA    = 3'h6,
      ST_DATA  = 3'h7
   } mgmt_state_t;

endpackage : phy_ctrl_pkg

`default_nettype wire

// >>> core/pin_sync3.sv
/*
 * Three-stage synchroniser with agreement filter for a group of
 * independent pin inputs.
 * Assumes each bit is a slow level; bits are not coherent with each other.
 */
`timescale 1ns/100ps
`default_nettype none

module pin_sync3 #(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         i_clk,
   input  wire logic         i_rst_b,
   input  wire logic         i_ce,
   // Pins in, settled levels out
   input  wire logic [W-1:0] i_pin,
   output logic      [W-1:0] o_level
);

   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;
   logic [W-1:0] level_reg;
   logic [W-1:0] level_next;

   // A change counts only once the second and third stages agree
   always_comb begin
      for (int i = 0; i < W; i++) begin
         level_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : level_reg[i];
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         s1_reg    <= '0;
         s2_reg    <= '0;
         s3_reg    <= '0;
         level_reg <= '0;
      end else if (i_ce) begin
         s1_reg    <= i_pin;
         s2_reg    <= s1_reg;
         s3_reg    <= s2_reg;
         level_reg <= level_next;
      end
   end

   assign o_level = level_reg;

endmodule : pin_sync3

`default_nettype wire

// >>> core/phy_basic_control.sv
/*
 * Basic control register of a 10/100 transceiver with its serial
 * management slave, mode arbitration between strap pins and register,
 * loopback, isolate, low-power and collision test steering.
 * Assumes the management clock and MAC transmit pins are asynchronous
 * and far slower than the system clock; negotiation results and line
 * receive signals come from logic on the system clock.
 */
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - One 16-bit control register reached over the serial management interface.
// - Writing one to bit 15 returns the control register to its defaults; the management slave keeps running.
// - During soft reset bit 15 reads one, writes ignored, self-clears after.
// - Bit 14 loopback disables line tx, rx, collision detect unless bit 7.
// - Loopback returns MAC transmit data to receive well inside 512 bit times.
// - Hardware mode without negotiation takes rate from the rate strap pin, bit 13 ignored.
// - Hardware mode reports active link rate on a rate status output.
// - Software mode with negotiation uses negotiated rate and duplex.
// - Software mode without negotiation: bit 13 zero 10 Mbps, one 100 Mbps.
// - Hardware mode takes negotiation enable from its strap pin.
// - Software mode: bit 12 enables negotiation; else bits 13, 8 fix mode.
// - Bit 11 low power: MAC outputs low, line transmitter tri-stated.
// - Entering low power keeps registers but resets latching status bits.
// - Bit 10 isolate: MAC outputs high impedance, MAC inputs ignored.
// - Isolate resets to one when strapped address is zero, else zero.
// - Software, no negotiation, no loopback: bit 8 selects half/full duplex.
// - Bit 9 restarts negotiation when enabled in software mode, self-clears once started.
// - With bit 7, COL follows TX_EN within 512 and 4 bit times.
module phy_basic_control (
   // Clock, reset, enable
   input  wire logic       I_CLK_SYS,
   input  wire logic       I_RST_B,
   input  wire logic       I_CE,
   // Serial management
   input  wire logic       I_MDC,
   input  wire logic       I_MDIO,
   output logic            O_MDIO,
   output logic            O_MDIO_OE,
   // Straps and mode pins
   input  wire logic [4:0] I_PHY_ADDR,
   input  wire logic       I_PIN_VS_REGISTER_MODE_SELECT,
   input  wire logic       I_RATE_STRAP_PIN,
   input  wire logic       I_NEGOTIATION_STRAP_PIN,
   input  wire logic       I_DUPLEX_STRAP_PIN,
   // Negotiation engine
   input  wire logic       I_NEG_RATE_100,
   input  wire logic       I_NEG_FULL_DUPLEX,
   input  wire logic       I_NEG_STARTED,
   output logic            O_NEG_ENABLE,
   output logic            O_NEG_RESTART,
   // Operating mode
   output logic            O_RATE_100,
   output logic            O_FULL_DUPLEX,
   output logic            O_RATE_STATUS,
   output logic            O_SOFT_RESET,
   output logic            O_LOW_POWER,
   output logic            O_LATCH_CLEAR,
   // Line side
   input  wire logic       I_LINE_RX_DV,
   input  wire logic [3:0] I_LINE_RXD,
   input  wire logic       I_LINE_COL,
   input  wire logic       I_LINE_CRS,
   output logic            O_LINE_TX_EN,
   output logic [3:0]      O_LINE_TXD,
   output logic            O_LINE_TX_TRISTATE,
   output logic            O_LINE_RX_ENABLE,
   output logic            O_COL_DETECT_ENABLE,
   // MAC side
   input  wire logic       I_TX_EN,
   input  wire logic [3:0] I_TXD,
   output logic            O_RX_DV,
   output logic [3:0]      O_RXD,
   output logic            O_COL,
   output logic            O_CRS,
   output logic            O_MAC_OE
);

   logic [1:0]  mgmt_pins;
   logic [8:0]  strap_pins;
   logic [4:0]  mac_pins;
   logic        mdc_lvl;
   logic        mdio_lvl;
   logic        sw_mode;
   logic        tx_en_s;
   logic [3:0]  txd_s;

   pin_sync3 #(.W(2)) u_sync_mgmt (
      .i_clk   (I_CLK_SYS),
      .i_rst_b (I_RST_B),
      .i_ce    (I_CE),
      .i_pin   ({I_MDC, I_MDIO}),
      .o_level (mgmt_pins)
   );

   pin_sync3 #(.W(9)) u_sync_strap (
      .i_clk   (I_CLK_SYS),
      .i_rst_b (I_RST_B),
      .i_ce    (I_CE),
      .i_pin   ({I_PHY_ADDR, I_PIN_VS_REGISTER_MODE_SELECT, I_RATE_STRAP_PIN,
                 I_NEGOTIATION_STRAP_PIN, I_DUPLEX_STRAP_PIN}),
      .o_level (strap_pins)
   );

   pin_sync3 #(.W(5)) u_sync_mac (
      .i_clk   (I_CLK_SYS),
      .i_rst_b (I_RST_B),
      .i_ce    (I_CE),
      .i_pin   ({I_TX_EN, I_TXD}),
      .o_level (mac_pins)
   );

   assign mdc_lvl  = mgmt_pins[1];
   assign mdio_lvl = mgmt_pins[0];
   assign sw_mode  = strap_pins[3];
   assign tx_en_s  = mac_pins[4];
   assign txd_s    = mac_pins[3:0];

   // Management frame slave
   phy_ctrl_pkg::mgmt_state_t state_reg, state_next;
   logic [5:0]  cnt_reg, cnt_next;
   logic [1:0]  op_reg, op_next;
   logic [9:0]  addr_reg, addr_next;
   logic [15:0] data_reg, data_next;
   logic        mdc_prev_reg, mdc_prev_next;
   logic        mdio_o_reg, mdio_o_next;
   logic        mdio_oe_reg, mdio_oe_next;
   logic        wr_stb_reg, wr_stb_next;
   logic        mdc_rise;
   logic [4:0]  phy_addr_reg;
   logic [15:0] ctrl_reg;
   logic [15:0] rd_value;

   assign mdc_rise = mdc_lvl & ~mdc_prev_reg;
   // Only register 0 lives here; other addresses of this port read zero
   assign rd_value = (addr_reg[4:0] == phy_ctrl_pkg::CTRL_REG_ADDR)
                     ? (ctrl_reg & phy_ctrl_pkg::CTRL_WRITE_MASK) : 16'h0000;

   always_comb begin
      state_next    = state_reg;
      cnt_next      = cnt_reg;
      op_next       = op_reg;
      addr_next     = addr_reg;
      data_next     = data_reg;
      mdc_prev_next = mdc_lvl;
      mdio_o_next   = mdio_o_reg;
      mdio_oe_next  = mdio_oe_reg;
      wr_stb_next   = 1'b0;
      if (mdc_rise) begin
         case (state_reg)
            phy_ctrl_pkg::ST_IDLE: begin
               if (mdio_lvl) begin
                  if (cnt_reg != phy_ctrl_pkg::PREAMBLE_BITS) begin
                     cnt_next = cnt_reg + 6'h01;
                  end
               end else begin
                  if (cnt_reg == phy_ctrl_pkg::PREAMBLE_BITS) begin
                     state_next = phy_ctrl_pkg::ST_START;
                  end
                  cnt_next = 6'h00;
               end
            end
            phy_ctrl_pkg::ST_START: begin
               state_next = mdio_lvl ? phy_ctrl_pkg::ST_OP : phy_ctrl_pkg::ST_IDLE;
               cnt_next   = 6'h00;
            end
            phy_ctrl_pkg::ST_OP: begin
               op_next  = {op_reg[0], mdio_lvl};
               cnt_next = cnt_reg + 6'h01;
               if (cnt_reg == phy_ctrl_pkg::OP_LAST) begin
                  state_next = phy_ctrl_pkg::ST_ADDR;
                  cnt_next   = 6'h00;
               end
            end
            phy_ctrl_pkg::ST_ADDR: begin
               addr_next = {addr_reg[8:0], mdio_lvl};
               cnt_next  = cnt_reg + 6'h01;
               if (cnt_reg == phy_ctrl_pkg::ADDR_LAST) begin
                  state_next = phy_ctrl_pkg::ST_TA;
                  cnt_next   = 6'h00;
               end
            end
            phy_ctrl_pkg::ST_TA: begin
               cnt_next = cnt_reg + 6'h01;
               if (cnt_reg == 6'h00) begin
                  // Second turnaround bit: drive zero on a read of our address
                  mdio_o_next  = 1'b0;
                  mdio_oe_next = (op_reg == phy_ctrl_pkg::OP_READ)
                                 && (addr_reg[9:5] == phy_addr_reg);
               end else begin
                  state_next  = phy_ctrl_pkg::ST_DATA;
                  cnt_next    = 6'h00;
                  data_next   = rd_value;
                  mdio_o_next = rd_value[15];
               end
            end
            phy_ctrl_pkg::ST_DATA: begin
               cnt_next    = cnt_reg + 6'h01;
               data_next   = mdio_oe_reg ? {data_reg[14:0], 1'b0}
                                         : {data_reg[14:0], mdio_lvl};
               mdio_o_next = data_reg[14];
               if (cnt_reg == phy_ctrl_pkg::DATA_LAST) begin
                  state_next   = phy_ctrl_pkg::ST_IDLE;
                  cnt_next     = 6'h00;
                  mdio_oe_next = 1'b0;
                  wr_stb_next  = (op_reg == phy_ctrl_pkg::OP_WRITE)
                                 && (addr_reg[9:5] == phy_addr_reg)
                                 && (addr_reg[4:0] == phy_ctrl_pkg::CTRL_REG_ADDR);
               end
            end
            default: begin
               state_next   = phy_ctrl_pkg::ST_IDLE;
               cnt_next     = 6'h00;
               mdio_oe_next = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
      if (!I_RST_B) begin
         state_reg    <= phy_ctrl_pkg::ST_IDLE;
         cnt_reg      <= 6'h00;
         op_reg       <= 2'h0;
         addr_reg     <= 10'h000;
         data_reg     <= 16'h0000;
         mdc_prev_reg <= 1'b0;
         mdio_o_reg   <= 1'b0;
         mdio_oe_reg  <= 1'b0;
         wr_stb_reg   <= 1'b0;
      end else if (I_CE) begin
         state_reg    <= state_next;
         cnt_reg      <= cnt_next;
         op_reg       <= op_next;
         addr_reg     <= addr_next;
         data_reg     <= data_next;
         mdc_prev_reg <= mdc_prev_next;
         mdio_o_reg   <= mdio_o_next;
         mdio_oe_reg  <= mdio_oe_next;
         wr_stb_reg   <= wr_stb_next;
      end
   end

   // Control register, strap capture and soft reset
   logic [15:0] ctrl_next;
   logic [4:0]  phy_addr_next;
   logic [2:0]  strap_cnt_reg, strap_cnt_next;
   logic [8:0]  srst_cnt_reg, srst_cnt_next;
   logic        iso_default_reg, iso_default_next;
   logic [15:0] wr_value;
   logic [15:0] defaults;

   // The write data sits in data_reg only after the final bit was shifted in
   assign wr_value = data_reg & phy_ctrl_pkg::CTRL_WRITE_MASK;
   assign defaults = phy_ctrl_pkg::CTRL_RESET_VALUE
                     | ({15'h0000, iso_default_reg} << phy_ctrl_pkg::BIT_ISOLATE);

   always_comb begin
      ctrl_next        = ctrl_reg;
      phy_addr_next    = phy_addr_reg;
      strap_cnt_next   = strap_cnt_reg;
      srst_cnt_next    = srst_cnt_reg;
      iso_default_next = iso_default_reg;
      if (strap_cnt_reg != phy_ctrl_pkg::STRAP_SETTLE) begin
         // Straps are taken once the synchroniser has settled after release
         strap_cnt_next = strap_cnt_reg + 3'h1;
         if (strap_cnt_reg == phy_ctrl_pkg::STRAP_SETTLE - 3'h1) begin
            phy_addr_next    = strap_pins[8:4];
            iso_default_next = (strap_pins[8:4] == 5'h00);
            ctrl_next[phy_ctrl_pkg::BIT_ISOLATE] = (strap_pins[8:4] == 5'h00);
         end
      end else if (ctrl_reg[phy_ctrl_pkg::BIT_SOFT_RESET]) begin
         // Writes are dropped while the reset runs; reads still answer and bit 15 stays one
         srst_cnt_next = srst_cnt_reg + 9'h001;
         if (srst_cnt_reg == phy_ctrl_pkg::SOFT_RESET_COUNT - 9'h001) begin
            ctrl_next     = defaults;
            srst_cnt_next = 9'h000;
         end
      end else begin
         if (I_NEG_STARTED) begin
            ctrl_next[phy_ctrl_pkg::BIT_NEG_RESTART] = 1'b0;
         end
         if (wr_stb_reg) begin
            ctrl_next = wr_value;
            // Restart only sticks with negotiation enabled in software mode
            ctrl_next[phy_ctrl_pkg::BIT_NEG_RESTART] =
               (wr_value[phy_ctrl_pkg::BIT_NEG_RESTART] & sw_mode
                & wr_value[phy_ctrl_pkg::BIT_NEG_EN])
               | (ctrl_reg[phy_ctrl_pkg::BIT_NEG_RESTART] & ~I_NEG_STARTED);
            if (wr_value[phy_ctrl_pkg::BIT_SOFT_RESET]) begin
               ctrl_next = defaults | 16'h8000;
            end
         end
      end
   end

   always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
      if (!I_RST_B) begin
         ctrl_reg        <= phy_ctrl_pkg::CTRL_RESET_VALUE;
         phy_addr_reg    <= 5'h00;
         strap_cnt_reg   <= 3'h0;
         srst_cnt_reg    <= 9'h000;
         iso_default_reg <= 1'b0;
      end else if (I_CE) begin
         ctrl_reg        <= ctrl_next;
         phy_addr_reg    <= phy_addr_next;
         strap_cnt_reg   <= strap_cnt_next;
         srst_cnt_reg    <= srst_cnt_next;
         iso_default_reg <= iso_default_next;
      end
   end

   // Operating mode and pin steering, all registered
   logic loop_on, lp_on, iso_on, col_test, neg_eff, rate_eff, dpx_eff, tx_act;
   logic [24:0] out_reg, out_next;
   logic        lp_prev_reg;

   assign loop_on  = ctrl_reg[phy_ctrl_pkg::BIT_LOOPBACK];
   assign lp_on    = ctrl_reg[phy_ctrl_pkg::BIT_LOW_POWER];
   assign iso_on   = ctrl_reg[phy_ctrl_pkg::BIT_ISOLATE];
   assign col_test = ctrl_reg[phy_ctrl_pkg::BIT_COL_TEST];
   // Pin settings win in hardware mode whatever the register holds
   assign neg_eff  = sw_mode ? ctrl_reg[phy_ctrl_pkg::BIT_NEG_EN] : strap_pins[1];
   assign rate_eff = neg_eff ? I_NEG_RATE_100
                   : (sw_mode ? ctrl_reg[phy_ctrl_pkg::BIT_RATE] : strap_pins[2]);
   assign dpx_eff  = (sw_mode && neg_eff) ? I_NEG_FULL_DUPLEX
                   : (!sw_mode ? strap_pins[0]
                   : (loop_on ? 1'b1 : ctrl_reg[phy_ctrl_pkg::BIT_DUPLEX]));
   assign tx_act   = tx_en_s & ~iso_on & ~lp_on;

   always_comb begin
      out_next = '0;
      out_next[0]     = neg_eff;
      out_next[1]     = ctrl_reg[phy_ctrl_pkg::BIT_NEG_RESTART];
      out_next[2]     = rate_eff;
      out_next[3]     = dpx_eff;
      out_next[4]     = rate_eff;
      out_next[5]     = ctrl_reg[phy_ctrl_pkg::BIT_SOFT_RESET];
      out_next[6]     = lp_on;
      out_next[7]     = lp_on & ~lp_prev_reg;
      out_next[8]     = tx_act & ~loop_on;
      out_next[12:9]  = (tx_act & ~loop_on) ? txd_s : 4'h0;
      out_next[13]    = lp_on | loop_on;
      out_next[14]    = ~lp_on & ~loop_on;
      out_next[15]    = ~lp_on & (~loop_on | col_test);
      if (!lp_on) begin
         out_next[16]    = loop_on ? tx_act : I_LINE_RX_DV;
         out_next[20:17] = loop_on ? (tx_act ? txd_s : 4'h0) : I_LINE_RXD;
         out_next[21]    = col_test ? tx_act : (~loop_on & I_LINE_COL);
         out_next[22]    = loop_on ? tx_act : I_LINE_CRS;
      end
      out_next[23]    = ~iso_on;
      out_next[24]    = 1'b0;
   end

   always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
      if (!I_RST_B) begin
         out_reg     <= '0;
         lp_prev_reg <= 1'b0;
      end else if (I_CE) begin
         out_reg     <= out_next;
         lp_prev_reg <= lp_on;
      end
   end

   assign O_MDIO              = mdio_o_reg;
   assign O_MDIO_OE           = mdio_oe_reg;
   assign O_NEG_ENABLE        = out_reg[0];
   assign O_NEG_RESTART       = out_reg[1];
   assign O_RATE_100          = out_reg[2];
   assign O_FULL_DUPLEX       = out_reg[3];
   assign O_RATE_STATUS       = out_reg[4];
   assign O_SOFT_RESET        = out_reg[5];
   assign O_LOW_POWER         = out_reg[6];
   assign O_LATCH_CLEAR       = out_reg[7];
   assign O_LINE_TX_EN        = out_reg[8];
   assign O_LINE_TXD          = out_reg[12:9];
   assign O_LINE_TX_TRISTATE  = out_reg[13];
   assign O_LINE_RX_ENABLE    = out_reg[14];
   assign O_COL_DETECT_ENABLE = out_reg[15];
   assign O_RX_DV             = out_reg[16];
   assign O_RXD               = out_reg[20:17];
   assign O_COL               = out_reg[21];
   assign O_CRS               = out_reg[22];
   assign O_MAC_OE            = out_reg[23];

endmodule : phy_basic_control

`default_nettype wire

// >>> bench/phy_ctrl_monitor.sv
/* Concurrent checks on the ports of the basic control register block.
   Assumes I_CE held high and one system clock domain. */
`timescale 1ns/100ps
`default_nettype none
module phy_ctrl_monitor (
   // Clock and reset
   input wire logic I_CLK_SYS,
   input wire logic I_RST_B,
   // Pins watched
   input wire logic I_PIN_VS_REGISTER_MODE_SELECT,
   input wire logic I_RATE_STRAP_PIN,
   input wire logic I_NEGOTIATION_STRAP_PIN,
   input wire logic I_NEG_RATE_100,
   input wire logic I_TX_EN,
   // Outputs watched
   input wire logic O_NEG_ENABLE,
   input wire logic O_RATE_100,
   input wire logic O_RATE_STATUS,
   input wire logic O_SOFT_RESET,
   input wire logic O_LOW_POWER,
   input wire logic O_LATCH_CLEAR,
   input wire logic O_LINE_TX_TRISTATE,
   input wire logic O_LINE_RX_ENABLE,
   input wire logic O_COL_DETECT_ENABLE,
   input wire logic O_RX_DV,
   input wire logic O_COL,
   input wire logic O_MAC_OE
);
   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (!I_RST_B);
   // Outside low power only loopback tri-states the line transmitter
   sequence loop_on;
      O_LINE_TX_TRISTATE && !O_LOW_POWER && O_MAC_OE;
   endsequence
   // Strap inputs pass a synchroniser, so give them cycles to settle
   sequence hw_steady;
      !I_PIN_VS_REGISTER_MODE_SELECT && !O_SOFT_RESET
         && $stable(I_RATE_STRAP_PIN) && $stable(I_NEGOTIATION_STRAP_PIN);
   endsequence
   a_low_power_quiet: assert property ($past(O_LOW_POWER) && O_LOW_POWER
      |-> !O_RX_DV && !O_COL && O_LINE_TX_TRISTATE) else $error("low power outputs");
   a_latch_clear_once: assert property (O_LATCH_CLEAR
      |=> O_LOW_POWER && !O_LATCH_CLEAR) else $error("latch clear pulse");
   a_loop_rx_off: assert property (loop_on ##0 $stable(O_LINE_TX_TRISTATE)
      |-> !O_LINE_RX_ENABLE) else $error("line receiver on in loopback");
   a_loop_rx_valid: assert property (loop_on ##0 $rose(I_TX_EN)
      |-> ##[1:20] O_RX_DV) else $error("loopback rx valid late");
   a_col_rise: assert property (loop_on ##0 O_COL_DETECT_ENABLE && $rose(I_TX_EN)
      |-> ##[1:20] O_COL) else $error("collision test rise late");
   a_col_fall: assert property (loop_on ##0 O_COL_DETECT_ENABLE && $fell(I_TX_EN)
      |-> ##[1:10] !O_COL) else $error("collision test fall late");
   a_hw_neg_pin: assert property (hw_steady [*8]
      |-> O_NEG_ENABLE == I_NEGOTIATION_STRAP_PIN) else $error("hardware negotiation");
   a_hw_rate_pin: assert property (hw_steady [*8] ##0 !I_NEGOTIATION_STRAP_PIN
      |-> O_RATE_100 == I_RATE_STRAP_PIN) else $error("hardware rate");
   a_rate_status: assert property ((!I_PIN_VS_REGISTER_MODE_SELECT && $stable(O_RATE_100))
      [*2] |-> O_RATE_STATUS == O_RATE_100) else $error("rate status");
   a_neg_result: assert property ((I_PIN_VS_REGISTER_MODE_SELECT && O_NEG_ENABLE
      && $stable(I_NEG_RATE_100)) [*4] |-> O_RATE_100 == I_NEG_RATE_100) else $error("neg rate");
endmodule : phy_ctrl_monitor
bind phy_basic_control phy_ctrl_monitor u_monitor (.*);
`default_nettype wire

// >>> bench/mgmt_station.sv
/* Management station model: sends serial management frames to register 0.
   Assumes the bench resolves the shared data line with a pull-up. */
`timescale 1ns/100ps
`default_nettype none
module mgmt_station (
   // Management clock and data
   output logic      o_mdc,
   output logic      o_mdio,
   output logic      o_mdio_oe,
   input  wire logic i_mdio
);
   initial begin
      o_mdc = 1'b0;
      o_mdio = 1'b1;
      o_mdio_oe = 1'b0;
   end
   // Clock stands low between frames; 160 ns period, data moves after the fall
   task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [15:0] wd,
                        output logic [15:0] rd);
      logic [63:0] bits;
      bits = {32'hFFFF_FFFF, 2'b01, op, phy, phy_ctrl_pkg::CTRL_REG_ADDR, 2'b10,
              wd & phy_ctrl_pkg::CTRL_WRITE_MASK};
      rd = 16'h0000;
      for (int i = 63; i >= 0; i--) begin
         o_mdio_oe = (op == phy_ctrl_pkg::OP_WRITE) || (i > 17);
         o_mdio = o_mdio_oe ? bits[i] : ~o_mdio;
         #80 o_mdc = 1'b1;
         if (i < 16) rd[i] = i_mdio;
         #80 o_mdc = 1'b0;
      end
      o_mdio_oe = 1'b0;
   endtask : frame
endmodule : mgmt_station
`default_nettype wire

// >>> bench/test_phy_basic_control.sv
/* Self-checking bench for the basic control register block.
   Assumes the management station model and the bound checker. */
`timescale 1ns/100ps
`default_nettype none
module test_phy_basic_control;
   logic        I_CLK_SYS, I_RST_B, I_CE, I_MDC, I_MDIO, O_MDIO, O_MDIO_OE, m_out, m_oe;
   logic [4:0]  I_PHY_ADDR;
   logic        I_PIN_VS_REGISTER_MODE_SELECT, I_RATE_STRAP_PIN, I_NEGOTIATION_STRAP_PIN;
   logic        I_DUPLEX_STRAP_PIN, I_NEG_RATE_100, I_NEG_FULL_DUPLEX, I_NEG_STARTED;
   logic        O_NEG_ENABLE, O_NEG_RESTART, O_RATE_100, O_FULL_DUPLEX, O_RATE_STATUS;
   logic        O_SOFT_RESET, O_LOW_POWER, O_LATCH_CLEAR, I_LINE_RX_DV, I_LINE_COL, I_LINE_CRS;
   logic [3:0]  I_LINE_RXD, O_LINE_TXD, I_TXD, O_RXD;
   logic        O_LINE_TX_EN, O_LINE_TX_TRISTATE, O_LINE_RX_ENABLE, O_COL_DETECT_ENABLE;
   logic        I_TX_EN, O_RX_DV, O_COL, O_CRS, O_MAC_OE;
   int          n_mismatch, tests_run, ctl, phy;
   logic [31:0] rnd;
   logic [15:0] rdata;
   phy_basic_control dut (.*);
   mgmt_station sme (.o_mdc(I_MDC), .o_mdio(m_out), .o_mdio_oe(m_oe), .i_mdio(I_MDIO));
   // Data line has a pull-up; whoever enables drives it
   assign I_MDIO = O_MDIO_OE ? O_MDIO : (m_oe ? m_out : 1'b1);
   initial begin
      I_CLK_SYS = 1'b0;
      forever #2 I_CLK_SYS = ~I_CLK_SYS;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic step(input int n);
      repeat (n) @(posedge I_CLK_SYS);
      #1;
   endtask : step
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [15:0] d);
      step(1);
      sme.frame(phy_ctrl_pkg::OP_WRITE, phy[4:0], d, rdata);
      step(10);
   endtask : wr
   task automatic rd(input logic [15:0] exp);
      step(1);
      sme.frame(phy_ctrl_pkg::OP_READ, phy[4:0], 16'h0000, rdata);
      chk("register read", exp, rdata);
      step(2);
   endtask : rd
   // Reference for the effective negotiation, rate and duplex
   task automatic mode(input logic sw);
      logic neg, rate, dup;
      neg = sw ? ctl[12] : I_NEGOTIATION_STRAP_PIN;
      rate = neg ? I_NEG_RATE_100 : (sw ? ctl[13] : I_RATE_STRAP_PIN);
      dup = neg ? I_NEG_FULL_DUPLEX : (sw ? ctl[14] | ctl[8] : I_DUPLEX_STRAP_PIN);
      step(12);
      chk("mode", {13'h0, neg, rate, dup}, {13'h0, O_NEG_ENABLE, O_RATE_100, O_FULL_DUPLEX});
   endtask : mode
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up
   initial begin
      #380000;
      n_mismatch++;
      wrap_up();
   end
   initial begin
      {I_RST_B, I_TX_EN, I_TXD, I_LINE_RX_DV, I_LINE_RXD, I_LINE_COL, I_LINE_CRS, I_NEG_STARTED,
       I_NEG_RATE_100, I_NEG_FULL_DUPLEX, I_RATE_STRAP_PIN, I_NEGOTIATION_STRAP_PIN,
       I_DUPLEX_STRAP_PIN, I_PHY_ADDR} = '0;
      {I_CE, I_PIN_VS_REGISTER_MODE_SELECT} = 2'h3;
      {n_mismatch, tests_run} = '0;
      rnd = 32'h0000BB8E;
      for (int a = 0; a < 2; a++) begin
         phy = a * 5;
         I_RST_B = 1'b0;
         I_PHY_ADDR = phy[4:0];
         step(8);
         I_RST_B = 1'b1;
         step(20);
         ctl = (a == 0) ? 32'h3400 : 32'h3000;
         chk("mac enable", {15'h0, a == 1}, {15'h0, O_MAC_OE});
         rd(ctl[15:0]);
      end
      for (int i = 0; i < 4; i++) begin
         ctl = (i[1] << 13) | (i[0] << 8);
         wr(ctl[15:0]);
         mode(1'b1);
         rd(ctl[15:0]);
      end
      rnd = lfsr(rnd);
      {I_NEG_RATE_100, I_NEG_FULL_DUPLEX} = rnd[1:0];
      ctl = 32'h1000;
      wr(16'h1000);
      mode(1'b1);
      wr(16'h1200);
      chk("restart", 16'h0001, {15'h0, O_NEG_RESTART});
      I_NEG_STARTED = 1'b1;
      step(1);
      I_NEG_STARTED = 1'b0;
      rd(16'h1000);
      wr(16'h0200);
      rd(16'h0000);
      I_PIN_VS_REGISTER_MODE_SELECT = 1'b0;
      wr(16'h2100);
      for (int i = 0; i < 6; i++) begin
         rnd = lfsr(rnd);
         {I_RATE_STRAP_PIN, I_NEGOTIATION_STRAP_PIN, I_DUPLEX_STRAP_PIN} = rnd[2:0];
         {I_NEG_RATE_100, I_NEG_FULL_DUPLEX} = {I_RATE_STRAP_PIN, I_DUPLEX_STRAP_PIN};
         mode(1'b0);
         chk("rate status", {15'h0, I_RATE_STRAP_PIN}, {15'h0, O_RATE_STATUS});
      end
      I_PIN_VS_REGISTER_MODE_SELECT = 1'b1;
      ctl = 32'h6080;
      wr(16'h6080);
      rnd = lfsr(rnd);
      I_TXD = rnd[3:0];
      I_LINE_RXD = ~rnd[3:0];
      I_TX_EN = 1'b1;
      mode(1'b1);
      chk("loopback", {7'h0, 2'h3, rnd[3:0], 3'h7}, {7'h0, O_CRS, O_RX_DV, O_RXD, O_COL,
          O_LINE_TX_TRISTATE, O_COL_DETECT_ENABLE});
      I_TX_EN = 1'b0;
      step(12);
      chk("loopback idle", 16'h0000, {14'h0, O_RX_DV, O_COL});
      wr(16'h4000);
      chk("loop line", 16'h0001, {13'h0, O_LINE_RX_ENABLE, O_COL_DETECT_ENABLE,
          O_LINE_TX_TRISTATE});
      wr(16'h2400);
      I_TX_EN = 1'b1;
      step(12);
      chk("isolate", 16'h0000, {14'h0, O_MAC_OE, O_LINE_TX_EN});
      I_TX_EN = 1'b0;
      I_LINE_RX_DV = 1'b1;
      wr(16'h2800);
      chk("low power", 16'h000D, {12'h0, O_LOW_POWER, O_LINE_TX_TRISTATE, O_RX_DV,
          O_MAC_OE});
      rd(16'h2800);
      I_LINE_RX_DV = 1'b0;
      wr(16'h8000);
      chk("soft reset", 16'h0001, {15'h0, O_SOFT_RESET});
      step(300);
      chk("soft reset end", 16'h0000, {15'h0, O_SOFT_RESET});
      rd(16'h3000);
      wrap_up();
   end
endmodule : test_phy_basic_control
`default_nettype wire
